// file: core/saic_pkg.sv
package saic_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_MISC = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_RUNTIME = 8'h10;

    // STATUS fields
    localparam int ST_FW_BAD_BIT = 0;
    localparam int ST_CFG_BAD_BIT = 1;
    localparam int ST_JTAG_BIT = 2;
    localparam int ST_ADDR_OK_BIT = 3;
    localparam int ST_BROWNOUT_BIT = 4;
    localparam int ST_STATE_LSB = 8;

    // MISC and CMD fields
    localparam int MISC_BROWNOUT_BIT = 0;
    localparam int CMD_SAVE_ALL_BIT = 0;
    localparam int CMD_WDT_KICK_BIT = 1;
    localparam logic [31:0] MISC_RESET = 32'h0000_0000;

    // Strap decode
    localparam logic [7:0] DEFAULT_ADDR = 8'h7E;
    localparam logic [7:0] ADDR_MULT = 8'h0C;
    localparam logic [3:0] BIN_MIN = 4'h4;
    localparam int BIN_COUNT = 8;
    localparam logic [3:0] BIN_BAD = 4'hF;
    localparam logic ADC_CH_LOWER = 1'b0;
    localparam logic ADC_CH_UPPER = 1'b1;
    // Lower edge of bins 4..11, then the top of bin 11; ratio 1.25 each
    localparam logic [11:0] BIN_EDGE [0:8] = '{
        12'h190, 12'h1F4, 12'h271, 12'h30D, 12'h3D1,
        12'h4C5, 12'h5F6, 12'h773, 12'h950
    };

    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int INIT_MS = 20;
    localparam int RESET_EXIT_MS = 1;
    localparam int WDT_MS = 100;

    // ECC geometry
    localparam int ECC_DATA_W = 32;
    localparam int ECC_CHK_W = 6;
    localparam int ECC_CODE_W = ECC_DATA_W + ECC_CHK_W;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_INIT = 2'b01,
        ST_RUN = 2'b10,
        ST_HALT = 2'b11
    } saic_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } saic_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } saic_apb_rsp_t;

endpackage

// file: core/saic_core.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module saic_core #(
    parameter int CYC_PER_MS = saic_pkg::CYC_PER_MS,
    parameter int WDT_MS = saic_pkg::WDT_MS
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // APB slave
    input wire saic_pkg::saic_apb_req_t apb_req,
    output saic_pkg::saic_apb_rsp_t apb_rsp,
    // Pins from outside the clock domain
    input wire logic ext_reset_b,
    input wire logic vcc_low,
    // Strap converter
    output logic adc_req,
    output logic adc_chan,
    output logic strap_bias_en,
    input wire logic adc_valid,
    input wire logic [11:0] adc_data,
    // Flash status and integrity checks
    input wire logic flash_blank,
    input wire logic fw_sum_ok,
    input wire logic cfg_sum_ok,
    // Flash commit and log control
    output logic load_defaults,
    output logic save_all_req,
    output logic brownout_commit,
    output logic flash_log_allow,
    // ECC datapath
    input wire logic [31:0] ecc_wr_data,
    output logic [37:0] ecc_wr_word,
    input wire logic [37:0] ecc_rd_word,
    output logic [31:0] ecc_rd_data,
    output logic ecc_corrected,
    // Pin control and status
    output logic fast_pwm_low,
    output logic io_release,
    output logic seq_enable,
    output logic alert_output_b,
    output logic jtag_en,
    output logic clk_slow_sel,
    output logic [7:0] bus_addr,
    output logic soft_reset
);

    localparam int TICK_W = $clog2(CYC_PER_MS + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYC_PER_MS - 1);
    localparam logic [15:0] INIT_LAST = 16'(saic_pkg::INIT_MS - 1);
    localparam logic [15:0] WDT_LAST = 16'(WDT_MS - 1);

    saic_pkg::saic_state_t state;
    saic_pkg::saic_state_t next_state;
    logic [1:0] rst_sync;
    logic [1:0] vcc_sync;
    logic vcc_low_q;
    logic [TICK_W-1:0] tick_cnt;
    logic ms_tick;
    logic [15:0] init_ms;
    logic [15:0] wdt_ms;
    logic wdt_expire;
    logic strap_upper;
    logic adc_busy;
    logic addr_latched;
    logic [3:0] lower_bin;
    logic fw_bad;
    logic cfg_bad;
    logic brownout_seen;
    logic [31:0] misc_cfg;
    logic [31:0] runtime;
    logic acc;
    logic wr_en;
    logic init_done;
    logic brownout_en;

    assign brownout_en = misc_cfg[saic_pkg::MISC_BROWNOUT_BIT];
    assign acc = apb_req.psel && apb_req.penable;
    assign wr_en = acc && apb_rsp.pready && apb_req.pwrite;
    assign init_done = (init_ms == INIT_LAST) && ms_tick && addr_latched;
    assign wdt_expire = (state == saic_pkg::ST_RUN) && ms_tick
        && (wdt_ms == WDT_LAST);

    // Map a strap reading to its bin; short or open both give BIN_BAD
    function automatic logic [3:0] bin_of(input logic [11:0] code);
        logic [3:0] bin;
        bin = saic_pkg::BIN_BAD;
        for (int i = 0; i < saic_pkg::BIN_COUNT; i++) begin
            if (code >= saic_pkg::BIN_EDGE[i]
                && code < saic_pkg::BIN_EDGE[i+1]) begin
                bin = saic_pkg::BIN_MIN + 4'(i);
            end
        end
        return bin;
    endfunction

    // Hamming layout: check bits at positions 1,2,4,8,16,32 of 1..38
    function automatic logic [37:0] ecc_encode(input logic [31:0] d);
        logic [37:0] cw;
        int k;
        cw = '0;
        k = 0;
        for (int p = 1; p <= saic_pkg::ECC_CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p-1] = d[k];
                k++;
            end
        end
        for (int c = 0; c < saic_pkg::ECC_CHK_W; c++) begin
            for (int p = 1; p <= saic_pkg::ECC_CODE_W; p++) begin
                if (((p >> c) & 1) == 1 && p != (1 << c)) begin
                    cw[(1<<c)-1] = cw[(1<<c)-1] ^ cw[p-1];
                end
            end
        end
        return cw;
    endfunction

    function automatic logic [5:0] ecc_syndrome(input logic [37:0] cw);
        logic [5:0] s;
        s = '0;
        for (int c = 0; c < saic_pkg::ECC_CHK_W; c++) begin
            for (int p = 1; p <= saic_pkg::ECC_CODE_W; p++) begin
                if (((p >> c) & 1) == 1) begin
                    s[c] = s[c] ^ cw[p-1];
                end
            end
        end
        return s;
    endfunction

    function automatic logic [31:0] ecc_extract(input logic [37:0] cw);
        logic [31:0] d;
        int k;
        d = '0;
        k = 0;
        for (int p = 1; p <= saic_pkg::ECC_CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[k] = cw[p-1];
                k++;
            end
        end
        return d;
    endfunction

    // Pin synchronisers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'h0;
            vcc_sync <= 2'h0;
            vcc_low_q <= 1'b0;
        end else if (ce) begin
            rst_sync <= {rst_sync[0], ext_reset_b};
            vcc_sync <= {vcc_sync[0], vcc_low};
            vcc_low_q <= vcc_sync[1];
        end
    end

    // Millisecond timebase shared by init, watchdog and run-time clock
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= '0;
            ms_tick <= 1'b0;
        end else if (ce) begin
            ms_tick <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
        end
    end

    // Restart sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            saic_pkg::ST_HOLD: begin
                if (rst_sync[1]) begin
                    next_state = saic_pkg::ST_INIT;
                end
            end
            saic_pkg::ST_INIT: begin
                if (init_done) begin
                    next_state = fw_sum_ok ? saic_pkg::ST_RUN
                        : saic_pkg::ST_HALT;
                end
            end
            saic_pkg::ST_RUN: begin
                if (wdt_expire) begin
                    next_state = saic_pkg::ST_INIT;
                end
            end
            saic_pkg::ST_HALT: begin
                next_state = saic_pkg::ST_HALT;
            end
        endcase
        if (!rst_sync[1]) begin
            next_state = saic_pkg::ST_HOLD;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= saic_pkg::ST_HOLD;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Init timer restarts on every entry to init
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            init_ms <= '0;
        end else if (ce) begin
            if (state != saic_pkg::ST_INIT) begin
                init_ms <= '0;
            end else if (ms_tick && init_ms != INIT_LAST) begin
                init_ms <= init_ms + 16'h0001;
            end
        end
    end

    // Firmware watchdog, kicked by the command register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wdt_ms <= '0;
            soft_reset <= 1'b0;
        end else if (ce) begin
            soft_reset <= wdt_expire;
            if (state != saic_pkg::ST_RUN || wdt_expire
                || (wr_en && apb_req.paddr == saic_pkg::OFS_CMD
                && apb_req.pwdata[saic_pkg::CMD_WDT_KICK_BIT])) begin
                wdt_ms <= '0;
            end else if (ms_tick) begin
                wdt_ms <= wdt_ms + 16'h0001;
            end
        end
    end

    // Strap capture; only power-on reset clears the latch
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            adc_req <= 1'b0;
            adc_chan <= saic_pkg::ADC_CH_LOWER;
            strap_bias_en <= 1'b0;
            adc_busy <= 1'b0;
            strap_upper <= 1'b0;
            addr_latched <= 1'b0;
            lower_bin <= saic_pkg::BIN_BAD;
            bus_addr <= saic_pkg::DEFAULT_ADDR;
            jtag_en <= 1'b0;
            clk_slow_sel <= 1'b0;
        end else if (ce) begin
            adc_req <= 1'b0;
            strap_bias_en <= (state == saic_pkg::ST_INIT)
                && !addr_latched;
            if (state == saic_pkg::ST_INIT && !addr_latched) begin
                if (!adc_busy) begin
                    adc_req <= 1'b1;
                    adc_chan <= strap_upper ? saic_pkg::ADC_CH_UPPER
                        : saic_pkg::ADC_CH_LOWER;
                    adc_busy <= 1'b1;
                end else if (adc_valid) begin
                    adc_busy <= 1'b0;
                    if (!strap_upper) begin
                        lower_bin <= bin_of(adc_data);
                        strap_upper <= 1'b1;
                    end else begin
                        addr_latched <= 1'b1;
                        if (lower_bin == saic_pkg::BIN_BAD
                            || bin_of(adc_data) == saic_pkg::BIN_BAD) begin
                            bus_addr <= saic_pkg::DEFAULT_ADDR;
                            jtag_en <= 1'b1;
                            clk_slow_sel <= 1'b1;
                        end else begin
                            bus_addr <= 8'(saic_pkg::ADDR_MULT
                                * {4'h0, bin_of(adc_data)}
                                + {4'h0, lower_bin});
                            jtag_en <= flash_blank;
                            clk_slow_sel <= flash_blank;
                        end
                    end
                end
            end
        end
    end

    // Integrity outcome flags; set wins over the software clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fw_bad <= 1'b0;
            cfg_bad <= 1'b0;
            load_defaults <= 1'b0;
            alert_output_b <= 1'b1;
        end else if (ce) begin
            load_defaults <= init_done && !cfg_sum_ok;
            if (init_done) begin
                fw_bad <= !fw_sum_ok;
            end
            if (init_done && !cfg_sum_ok) begin
                cfg_bad <= 1'b1;
            end else if (wr_en && apb_req.paddr == saic_pkg::OFS_STATUS
                && apb_req.pwdata[saic_pkg::ST_CFG_BAD_BIT]) begin
                cfg_bad <= 1'b0;
            end
            alert_output_b <= !(cfg_bad || (init_done && !cfg_sum_ok));
        end
    end

    // Config register and flash commit requests
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            misc_cfg <= saic_pkg::MISC_RESET;
            save_all_req <= 1'b0;
            brownout_commit <= 1'b0;
            brownout_seen <= 1'b0;
            flash_log_allow <= 1'b1;
        end else if (ce) begin
            if (wr_en && apb_req.paddr == saic_pkg::OFS_MISC) begin
                misc_cfg <= apb_req.pwdata;
            end
            save_all_req <= wr_en && apb_req.paddr == saic_pkg::OFS_CMD
                && apb_req.pwdata[saic_pkg::CMD_SAVE_ALL_BIT];
            brownout_commit <= brownout_en && vcc_sync[1]
                && !vcc_low_q;
            if (brownout_en && vcc_sync[1] && !vcc_low_q) begin
                brownout_seen <= 1'b1;
            end
            flash_log_allow <= !brownout_en;
        end
    end

    // Run-time clock in milliseconds
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            runtime <= '0;
        end else if (ce) begin
            if (wr_en && apb_req.paddr == saic_pkg::OFS_RUNTIME) begin
                runtime <= apb_req.pwdata;
            end else if (state == saic_pkg::ST_HOLD && !brownout_en) begin
                runtime <= '0;
            end else if (wdt_expire && !brownout_en) begin
                runtime <= '0;
            end else if (state == saic_pkg::ST_RUN && ms_tick) begin
                runtime <= runtime + 32'h0000_0001;
            end
        end
    end

    // Pin states follow the restart state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fast_pwm_low <= 1'b1;
            io_release <= 1'b0;
            seq_enable <= 1'b0;
        end else if (ce) begin
            fast_pwm_low <= (next_state != saic_pkg::ST_RUN)
                || flash_blank;
            io_release <= (next_state == saic_pkg::ST_RUN)
                && !flash_blank;
            seq_enable <= (next_state == saic_pkg::ST_RUN)
                && !flash_blank;
        end
    end

    // ECC encode on write, single-error correction on read
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ecc_wr_word <= '0;
            ecc_rd_data <= '0;
            ecc_corrected <= 1'b0;
        end else if (ce) begin
            ecc_wr_word <= ecc_encode(ecc_wr_data);
            ecc_corrected <= (ecc_syndrome(ecc_rd_word) != 6'h00);
            if (ecc_syndrome(ecc_rd_word) != 6'h00
                && ecc_syndrome(ecc_rd_word) <= 6'(saic_pkg::ECC_CODE_W)) begin
                ecc_rd_data <= ecc_extract(ecc_rd_word
                    ^ (38'h1 << (ecc_syndrome(ecc_rd_word) - 6'h01)));
            end else begin
                ecc_rd_data <= ecc_extract(ecc_rd_word);
            end
        end
    end

    // APB: pready one cycle into the access phase
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            apb_rsp <= '0;
        end else if (ce) begin
            apb_rsp.pready <= acc && !apb_rsp.pready;
            apb_rsp.pslverr <= 1'b0;
            apb_rsp.prdata <= '0;
            if (acc && !apb_rsp.pready) begin
                unique case (apb_req.paddr)
                    saic_pkg::OFS_STATUS: begin
                        apb_rsp.prdata[saic_pkg::ST_FW_BAD_BIT] <= fw_bad;
                        apb_rsp.prdata[saic_pkg::ST_CFG_BAD_BIT] <= cfg_bad;
                        apb_rsp.prdata[saic_pkg::ST_JTAG_BIT] <= jtag_en;
                        apb_rsp.prdata[saic_pkg::ST_ADDR_OK_BIT]
                            <= addr_latched;
                        apb_rsp.prdata[saic_pkg::ST_BROWNOUT_BIT]
                            <= brownout_seen;
                        apb_rsp.prdata[saic_pkg::ST_STATE_LSB +: 2] <= state;
                    end
                    saic_pkg::OFS_ADDR: begin
                        apb_rsp.prdata[7:0] <= bus_addr;
                    end
                    saic_pkg::OFS_MISC: begin
                        apb_rsp.prdata <= misc_cfg;
                    end
                    saic_pkg::OFS_CMD: begin
                        apb_rsp.prdata <= '0;
                    end
                    saic_pkg::OFS_RUNTIME: begin
                        apb_rsp.prdata <= runtime;
                    end
                    default: begin
                        apb_rsp.pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // saic_core

// file: test/saic_strap_adc.sv
`timescale 1ns/100ps
module saic_strap_adc (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Sample request from the block
    input wire logic adc_req,
    input wire logic adc_chan,
    // Strap codes and answer delay set by the bench
    input wire logic [11:0] code_lower,
    input wire logic [11:0] code_upper,
    input wire logic [3:0] delay,
    // Converter answer
    output logic adc_valid,
    output logic [11:0] adc_data
);
    logic [4:0] wait_cnt;
    logic chan_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 5'h00;
            chan_q <= 1'b0;
            adc_valid <= 1'b0;
            adc_data <= 12'hA5A;
        end else begin
            adc_valid <= 1'b0;
            // Data means nothing without the strobe, so keep it moving
            adc_data <= ~adc_data;
            if (adc_req) begin
                wait_cnt <= {1'b0, delay} + 5'h01;
                chan_q <= adc_chan;
            end else if (wait_cnt == 5'h01) begin
                wait_cnt <= 5'h00;
                adc_valid <= 1'b1;
                adc_data <= chan_q ? code_upper : code_lower;
            end else if (wait_cnt != 5'h00) begin
                wait_cnt <= wait_cnt - 5'h01;
            end
        end
    end
endmodule // saic_strap_adc

// file: test/saic_core_checker.sv
`timescale 1ns/100ps
module saic_core_checker #(
    parameter int CYC_PER_MS = 4,
    parameter int WDT_MS = 10
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Block inputs
    input wire saic_pkg::saic_apb_req_t apb_req,
    input wire logic ext_reset_b,
    input wire logic vcc_low,
    input wire logic adc_valid,
    input wire logic flash_blank,
    // Block outputs
    input wire saic_pkg::saic_apb_rsp_t apb_rsp,
    input wire logic adc_req,
    input wire logic strap_bias_en,
    input wire logic load_defaults,
    input wire logic save_all_req,
    input wire logic brownout_commit,
    input wire logic flash_log_allow,
    input wire logic fast_pwm_low,
    input wire logic io_release,
    input wire logic seq_enable,
    input wire logic alert_output_b,
    input wire logic jtag_en,
    input wire logic clk_slow_sel,
    input wire logic [7:0] bus_addr,
    input wire logic soft_reset
);
    logic cmd_save;
    assign cmd_save = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == saic_pkg::OFS_CMD && apb_req.pwdata[0];

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_apb_answer: assert property (
        apb_req.psel && apb_req.penable && !apb_rsp.pready
        |=> apb_rsp.pready) else $error("access not answered");
    a_addr_latch: assert property (
        $changed(bus_addr) |-> $past(adc_valid) || $past(adc_valid, 2))
        else $error("address changed without a sample");
    a_jtag_default: assert property (
        $rose(jtag_en) && !flash_blank |-> bus_addr == 8'h7E)
        else $error("test port on without default address");
    a_slow_clock: assert property (clk_slow_sel == jtag_en)
        else $error("clock slowdown differs from test port");
    a_pins_safe: assert property (
        fast_pwm_low |-> !io_release && !seq_enable)
        else $error("outputs released while pwm held");
    a_ext_hold: assert property (
        !ext_reset_b [*5] |-> fast_pwm_low && !seq_enable)
        else $error("pins not safe in hard reset");
    a_wdt_restart: assert property (
        soft_reset |-> ##[0:1] (fast_pwm_low && !seq_enable))
        else $error("watchdog restart left pins active");
    a_commit_prompt: assert property (
        $rose(vcc_low) && !flash_log_allow |-> ##[1:5] brownout_commit)
        else $error("no log commit on brownout");
    a_cfg_alert: assert property (
        load_defaults |-> ##[0:1] !alert_output_b)
        else $error("alert missing after defaults");
    a_save_cause: assert property (
        save_all_req |-> $past(cmd_save) || $past(cmd_save, 2))
        else $error("save without command");
    a_strap_bias: assert property (
        adc_req |-> strap_bias_en) else $error("sample without bias");

    cover property (brownout_commit);
    cover property (soft_reset);
    cover property (load_defaults);
endmodule // saic_core_checker

bind saic_core saic_core_checker #(
    .CYC_PER_MS(CYC_PER_MS),
    .WDT_MS(WDT_MS)
) u_chk (.*);

// file: test/saic_core_bench.sv
`timescale 1ns/100ps
module saic_core_bench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic ext_reset_b = 1'b1;
    logic vcc_low = 1'b0;
    logic flash_blank = 1'b0;
    logic fw_sum_ok = 1'b1;
    logic cfg_sum_ok = 1'b1;
    logic [11:0] code_lower = 12'h3D1;
    logic [11:0] code_upper = 12'h270;
    logic [3:0] adc_delay = 4'h0;
    saic_pkg::saic_apb_req_t apb_req = '0;
    saic_pkg::saic_apb_rsp_t apb_rsp;
    logic [31:0] ecc_wr_data = 32'h5A3C_96E1;
    logic [37:0] ecc_rd_word = 38'h15_5555_5555;
    logic [37:0] ecc_wr_word, w;
    logic [31:0] ecc_rd_data, rd;
    logic [11:0] adc_data;
    logic [7:0] bus_addr;
    logic adc_req, adc_chan, strap_bias_en, adc_valid, err;
    logic load_defaults, save_all_req, brownout_commit, flash_log_allow;
    logic ecc_corrected, fast_pwm_low, io_release, seq_enable;
    logic alert_output_b, jtag_en, clk_slow_sel, soft_reset;
    int fail_count = 0, n_checks = 0, cycles = 0;
    int n_load = 0, n_save = 0, n_commit = 0, n_soft = 0;
    // Straps avoid addresses 0, 11, 12 and 127
    logic [11:0] lo_t [4] = '{12'h3D1, 12'h18F, 12'h200, 12'h94F};
    logic [11:0] up_t [4] = '{12'h270, 12'h300, 12'h950, 12'h190};
    logic [7:0] ad_t [4] = '{8'h44, 8'h7E, 8'h7E, 8'h3B};

    always #50 clk_sys = ~clk_sys;

    saic_core #(.CYC_PER_MS(4), .WDT_MS(10)) u_dut (.*);
    saic_strap_adc u_adc (
        .clk_sys, .rst_b, .adc_req, .adc_chan, .code_lower, .code_upper,
        .delay(adc_delay), .adc_valid, .adc_data
    );

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (load_defaults === 1'b1) n_load++;
        if (save_all_req === 1'b1) n_save++;
        if (brownout_commit === 1'b1) n_commit++;
        if (soft_reset === 1'b1) n_soft++;
        if (cycles == 6000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int t;
        t = 0;
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            t++;
        end while (apb_rsp.pready !== 1'b1 && t < 16);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        if (t == 16) fail_count++;
        apb_req <= '0;
        @(posedge clk_sys);
    endtask

    task automatic wait_run();
        int t;
        t = 0;
        do begin
            apb(1'b0, saic_pkg::OFS_STATUS, 32'h0);
            t++;
        end while (rd[9:8] < 2'h2 && t < 80);
        if (t == 80) fail_count++;
    endtask

    task automatic powerup(logic [11:0] lo, up, logic blank, fw, cfg);
        rst_b <= 1'b0;
        code_lower <= lo;
        code_upper <= up;
        flash_blank <= blank;
        fw_sum_ok <= fw;
        cfg_sum_ok <= cfg;
        repeat (2) @(posedge clk_sys);
        n_load = 0;
        n_save = 0;
        n_commit = 0;
        n_soft = 0;
        check("reset pins", {fast_pwm_low, io_release, seq_enable,
            alert_output_b, jtag_en, bus_addr}, 32'h127E);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        wait_run();
    endtask

    initial begin
        powerup(12'h3D1, 12'h270, 1'b1, 1'b1, 1'b1);
        check("blank status", rd, 32'h20C);
        check("blank pins", {fast_pwm_low, io_release, seq_enable}, 32'h4);
        powerup(12'h3D1, 12'h270, 1'b0, 1'b0, 1'b1);
        check("halt status", rd, 32'h309);
        check("halt seq", seq_enable, 1'b0);
        powerup(12'h3D1, 12'h270, 1'b0, 1'b1, 1'b0);
        apb(1'b0, saic_pkg::OFS_STATUS, 32'h0);
        check("cfg status", rd, 32'h20A);
        check("defaults", n_load, 1);
        check("alert", alert_output_b, 1'b0);
        apb(1'b1, saic_pkg::OFS_STATUS, 32'h2);
        apb(1'b0, saic_pkg::OFS_STATUS, 32'h0);
        check("cfg cleared", rd[1], 1'b0);
        for (int i = 0; i < 4; i++) begin
            adc_delay <= 4'(i * 3);
            powerup(lo_t[i], up_t[i], 1'b0, 1'b1, 1'b1);
            check("status", rd, ad_t[i] == 8'h7E ? 32'h20C : 32'h208);
            check("run pins", {fast_pwm_low, io_release, seq_enable}, 32'h3);
            check("address", bus_addr, ad_t[i]);
            check("slow clock", clk_slow_sel, ad_t[i] == 8'h7E);
            apb(1'b0, saic_pkg::OFS_ADDR, 32'h0);
            check("address reg", rd, ad_t[i]);
        end
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        check("unmapped", err, 1'b1);
        apb(1'b0, saic_pkg::OFS_MISC, 32'h0);
        check("misc reset", rd, saic_pkg::MISC_RESET);
        apb(1'b1, saic_pkg::OFS_CMD, 32'h1);
        repeat (2) @(posedge clk_sys);
        check("save", n_save, 1);
        repeat (12) apb(1'b1, saic_pkg::OFS_CMD, 32'h2);
        check("kicked", n_soft, 0);
        apb(1'b1, saic_pkg::OFS_RUNTIME, 32'h1000);
        repeat (60) @(posedge clk_sys);
        check("expired", n_soft, 1);
        apb(1'b0, saic_pkg::OFS_RUNTIME, 32'h0);
        check("runtime cleared", rd < 32'h1000, 1'b1);
        wait_run();
        apb(1'b1, saic_pkg::OFS_MISC, 32'h1);
        @(posedge clk_sys);
        check("sram logging", flash_log_allow, 1'b0);
        apb(1'b1, saic_pkg::OFS_RUNTIME, 32'h1000);
        repeat (60) @(posedge clk_sys);
        apb(1'b0, saic_pkg::OFS_RUNTIME, 32'h0);
        check("runtime kept", n_soft == 2 && rd >= 32'h1000, 1'b1);
        vcc_low <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check("commit", n_commit, 1);
        vcc_low <= 1'b0;
        apb(1'b1, saic_pkg::OFS_MISC, 32'h0);
        @(posedge clk_sys);
        check("flash logging", flash_log_allow, 1'b1);
        vcc_low <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check("no commit", n_commit, 1);
        code_lower <= 12'h190;
        ext_reset_b <= 1'b0;
        repeat (10) @(posedge clk_sys);
        check("hard reset", {fast_pwm_low, seq_enable}, 32'h2);
        ext_reset_b <= 1'b1;
        repeat (7) @(posedge clk_sys);
        apb(1'b0, saic_pkg::OFS_STATUS, 32'h0);
        check("left reset", rd[9:8], 2'h1);
        wait_run();
        check("address kept", bus_addr, 8'h3B);
        w = ecc_wr_word;
        for (int k = -1; k < 38; k += 19) begin
            ecc_rd_word <= (k < 0) ? w : w ^ (38'h1 << k);
            repeat (2) @(posedge clk_sys);
            check("ecc data", ecc_rd_data, 32'h5A3C_96E1);
            check("ecc flag", ecc_corrected, k >= 0);
        end
        summarize();
    end
endmodule // saic_core_bench
